// >>> shared/cadc_pkg.sv
// constants, types and helpers for the counter-ramp converter control
// assumes a single 125 MHz clock and an external comparator and ladder network
//
// Contract
// - A start request clears the count to zero and launches exactly one pulse into the loop.
// - Each trip of the pulse around the loop, except the last one, adds exactly one to the count.
// - Once the comparator trips, the next loop pulse sets done and stops pulse and count.
// - The counter clearing pulse lasts about 400 ns and is of fixed width.
// - An N-bit conversion may take up to 2 to the N steps, half that on average.
// - The loop chains at least two delay elements so each recovers before the pulse returns.
// - One loop trip covers comparator settling of 0.15 plus 0.05N us and the other delays.
// - The comparator is synchronised, never gates the counter directly, done set normally.
package cadc_pkg;

	// ----------------------------------------------------------------
	// sizes and clock
	// ----------------------------------------------------------------
	localparam int CADC_BITS   = 8;                  // counter and ladder width
	localparam int CADC_CLK_MHZ = 125;               // clock rate
	localparam int CADC_TMR_W  = 8;                  // width of the small timers

	typedef logic [CADC_BITS-1:0]  cadc_count_t;
	typedef logic [CADC_TMR_W-1:0] cadc_tmr_t;

	// round a time in ns up to whole clock cycles, never below one
	function automatic int cadc_cyc_up(input int ns);
		int cyc;
		cyc = (ns * CADC_CLK_MHZ + 999) / 1000;
		return (cyc < 1) ? 1 : cyc;
	endfunction

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CADC_CLR_NS         = 400;        // clearing pulse width
	localparam int CADC_CLR_CYC        = cadc_cyc_up(CADC_CLR_NS);
	localparam int CADC_SETTLE_BASE_NS = 150;        // comparator settling, fixed part
	localparam int CADC_SETTLE_BIT_NS  = 50;         // comparator settling, per bit
	localparam int CADC_STEP_NS        = CADC_SETTLE_BASE_NS + CADC_SETTLE_BIT_NS * CADC_BITS;
	localparam int CADC_STEP_CYC       = cadc_cyc_up(CADC_STEP_NS);
	localparam int CADC_STAGES         = 2;          // delay elements in the loop
	localparam int CADC_STAGE_CYC      = (CADC_STEP_CYC + CADC_STAGES - 1) / CADC_STAGES;

	localparam cadc_tmr_t   CADC_CLR_LAST   = cadc_tmr_t'(CADC_CLR_CYC - 1);
	localparam cadc_tmr_t   CADC_STAGE_LOAD = cadc_tmr_t'(CADC_STAGE_CYC - 1);
	localparam cadc_tmr_t   CADC_TMR_ZERO   = 8'h00;
	localparam cadc_count_t CADC_COUNT_ZERO = 8'h00;
	localparam cadc_count_t CADC_COUNT_FULL = 8'hFF;

	// ----------------------------------------------------------------
	// control states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CADC_IDLE  = 3'h1,
		CADC_CLEAR = 3'h2,
		CADC_RUN   = 3'h4
	} cadc_state_t;

endpackage

// >>> shared/cadc_loop_if.sv
// signals between the converter control and its recirculating delay loop
// assumes both ends share one clock and reset
`timescale 1ns/10ps
interface cadc_loop_if;
	logic inject;   // one-cycle pulse that enters the loop
	logic inhibit;  // level that flushes the loop
	logic pulse;    // one-cycle pulse when a trip completes

	modport ctrl (output inject, output inhibit, input pulse);
	modport loop (input inject, input inhibit, output pulse);
endinterface

// >>> core/cadc_delay_loop.sv
// recirculating delay loop: a chain of timed delay elements
// assumes inject is never raised while a pulse is still inside the loop
`timescale 1ns/10ps
module cadc_delay_loop
	import cadc_pkg::*;
(
	input  wire logic  clock_i,
	input  wire logic  rst_i,
	cadc_loop_if.loop  lp
);

	// ----------------------------------------------------------------
	// delay elements
	// ----------------------------------------------------------------
	cadc_tmr_t                cnt [CADC_STAGES];
	logic [CADC_STAGES-1:0]   active;
	logic [CADC_STAGES-1:0]   fire;
	logic [CADC_STAGES-1:0]   trig;

	// each element is triggered by the previous one, the first by inject
	assign trig     = {fire[CADC_STAGES-2:0], lp.inject};
	assign lp.pulse = fire[CADC_STAGES-1];

	// each element holds the pulse for a fixed count, then passes it on
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			active <= '0;
			fire   <= '0;
			for (int k = 0; k < CADC_STAGES; k++) begin
				cnt[k] <= CADC_TMR_ZERO;
			end
		end else begin
			for (int k = 0; k < CADC_STAGES; k++) begin
				fire[k] <= 1'b0;
				if (lp.inhibit) begin
					active[k] <= 1'b0;
				end else if (trig[k]) begin
					active[k] <= 1'b1;
					cnt[k]    <= CADC_STAGE_LOAD;
				end else if (active[k]) begin
					if (cnt[k] == CADC_TMR_ZERO) begin
						active[k] <= 1'b0;
						fire[k]   <= 1'b1;
					end else begin
						cnt[k] <= cadc_tmr_t'(cnt[k] - 1'b1);
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	localparam int LOOP_MIN = CADC_STAGES * CADC_STAGE_CYC;
	logic [9:0] since_inj;  // cycles since the last inject

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			since_inj <= 10'h000;
		end else if (lp.inject) begin
			since_inj <= 10'h000;
		end else if (since_inj != 10'h3FF) begin
			since_inj <= since_inj + 10'h001;
		end
	end

	property p_stage_recovered;
		@(posedge clock_i) disable iff (rst_i) (trig & active) == '0;
	endproperty
	a_stage_recovered: assert property (p_stage_recovered)
		else $error("delay element retriggered before recovery");

	property p_loop_period;
		@(posedge clock_i) disable iff (rst_i) lp.pulse |-> since_inj >= 10'(LOOP_MIN);
	endproperty
	a_loop_period: assert property (p_loop_period)
		else $error("loop trip shorter than the step time");

endmodule

// >>> core/cadc_ctrl.sv
// control for a counter-ramp analog-to-digital converter
// assumes the ladder is driven from count_o and the comparator answers on cmp_i
`timescale 1ns/10ps
module cadc_ctrl
	import cadc_pkg::*;
(
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         start_i,   // start request, async pin
	input  wire logic         cmp_i,     // comparator: ladder reached input, async pin
	output cadc_count_t       count_o,   // conversion counter, drives ladder
	output logic              clear_o,   // counter clearing pulse
	output logic              busy_o,    // conversion in progress
	output logic              done_o     // end of conversion
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic start_s1;
	logic start_s2;
	logic start_d;
	logic cmp_s1;
	logic cmp_s2;

	// two flops on each pin, plus one for the start edge
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
			start_d  <= 1'b0;
			cmp_s1   <= 1'b0;
			cmp_s2   <= 1'b0;
		end else begin
			start_s1 <= start_i;
			start_s2 <= start_s1;
			start_d  <= start_s2;
			cmp_s1   <= cmp_i;
			cmp_s2   <= cmp_s1;
		end
	end

	// ----------------------------------------------------------------
	// loop
	// ----------------------------------------------------------------
	cadc_loop_if lp ();

	cadc_delay_loop u_loop (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.lp      (lp.loop)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	cadc_state_t state;
	cadc_state_t next_state;
	cadc_tmr_t   clr_cnt;
	logic        inject;

	wire in_idle    = (state == CADC_IDLE);
	wire in_clear   = (state == CADC_CLEAR);
	wire in_run     = (state == CADC_RUN);
	wire start_edge = start_s2 & ~start_d;
	wire take_start = in_idle & start_edge;
	wire clr_last   = in_clear & (clr_cnt == CADC_CLR_LAST);
	wire step       = in_run & lp.pulse;
	wire at_full    = (count_o == CADC_COUNT_FULL);
	wire finish     = step & (cmp_s2 | at_full);
	wire advance    = step & ~finish;

	assign lp.inject  = inject;
	assign lp.inhibit = ~in_run;

	// state sequence
	always_comb begin
		next_state = state;
		case (state)
			CADC_IDLE: begin
				if (start_edge) begin
					next_state = CADC_CLEAR;
				end
			end
			CADC_CLEAR: begin
				if (clr_last) begin
					next_state = CADC_RUN;
				end
			end
			CADC_RUN: begin
				if (finish) begin
					next_state = CADC_IDLE;
				end
			end
			default: begin
				next_state = CADC_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// state and clearing timer
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state   <= CADC_IDLE;
			clr_cnt <= CADC_TMR_ZERO;
		end else begin
			state   <= next_state;
			clr_cnt <= in_clear ? cadc_tmr_t'(clr_cnt + 1'b1) : CADC_TMR_ZERO;
		end
	end

	// counter, done flag and loop injection
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= CADC_COUNT_ZERO;
			done_o  <= 1'b0;
			inject  <= 1'b0;
		end else begin
			inject <= clr_last | advance;
			if (take_start) begin
				count_o <= CADC_COUNT_ZERO;
				done_o  <= 1'b0;
			end else if (advance) begin
				count_o <= cadc_count_t'(count_o + 1'b1);
			end else if (finish) begin
				done_o <= 1'b1;
			end
		end
	end

	// status outputs follow the next state
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			clear_o <= 1'b0;
			busy_o  <= 1'b0;
		end else begin
			clear_o <= (next_state == CADC_CLEAR);
			busy_o  <= (next_state != CADC_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	cadc_tmr_t clr_seen;  // length of the current clearing pulse

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			clr_seen <= CADC_TMR_ZERO;
		end else begin
			clr_seen <= clear_o ? cadc_tmr_t'(clr_seen + 1'b1) : CADC_TMR_ZERO;
		end
	end

	property p_start_clears;
		take_start |=> clear_o && (count_o == CADC_COUNT_ZERO) && !done_o;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("start did not clear the counter");

	property p_inject_once;
		clr_last |=> lp.inject ##1 !lp.inject;
	endproperty
	a_inject_once: assert property (p_inject_once)
		else $error("start did not launch exactly one pulse");

	property p_step_adds_one;
		advance |=> count_o == cadc_count_t'($past(count_o) + 1'b1);
	endproperty
	a_step_adds_one: assert property (p_step_adds_one)
		else $error("loop trip did not add one count");

	property p_cmp_stops;
		(step && cmp_s2) |=> done_o && !busy_o && lp.inhibit && !lp.inject;
	endproperty
	a_cmp_stops: assert property (p_cmp_stops)
		else $error("comparator trip did not end the conversion");

	property p_clear_width;
		$fell(clear_o) |-> clr_seen == cadc_tmr_t'(CADC_CLR_CYC);
	endproperty
	a_clear_width: assert property (p_clear_width)
		else $error("clearing pulse has the wrong width");

	property p_full_stops;
		(step && at_full) |=> done_o && (count_o == CADC_COUNT_FULL);
	endproperty
	a_full_stops: assert property (p_full_stops)
		else $error("counter wrapped past full scale");

	property p_count_only_on_pulse;
		$changed(count_o) |-> $past(lp.pulse) || $past(take_start);
	endproperty
	a_count_only_on_pulse: assert property (p_count_only_on_pulse)
		else $error("count changed without a loop pulse");

	property p_done_only_on_pulse;
		$rose(done_o) |-> $past(step);
	endproperty
	a_done_only_on_pulse: assert property (p_done_only_on_pulse)
		else $error("done set outside a loop pulse");

	property p_result_held;
		(done_o && !take_start) |=> done_o && $stable(count_o);
	endproperty
	a_result_held: assert property (p_result_held)
		else $error("result changed before the next start");

	// a start edge while running is ignored: no new clear, counting goes on
	property p_busy_start_ignored;
		(start_edge && in_run && !finish) |=> busy_o && !clear_o && !done_o;
	endproperty
	a_busy_start_ignored: assert property (p_busy_start_ignored)
		else $error("start request disturbed a running conversion");

	// scenarios worth seeing in a run
	c_cmp_finish:  cover property (step && cmp_s2);
	c_full_finish: cover property (step && at_full);
	c_restart:     cover property (done_o && take_start);
	c_busy_start:  cover property (start_edge && in_run);
	c_clear_end:   cover property ($fell(clear_o));

endmodule

// >>> tb/cadc_cmp_model.sv
// comparator and ladder model facing the converter control
// assumes count_i is the ladder code and level_i the analog input in counts
`timescale 1ns/10ps
module cadc_cmp_model
	import cadc_pkg::*;
#(
	parameter int SETTLE_CYC = 20
)
(
	input  wire logic        clock_i,
	input  wire cadc_count_t count_i,
	input  wire logic [8:0]  level_i,
	input  wire logic        glitch_i,
	output logic             cmp_o
);
	// ------------
	// settling
	// ------------
	int          age  = 0;
	cadc_count_t last = 8'h00;

	// restart the settling count whenever the ladder code moves
	always_ff @(posedge clock_i) begin
		last <= count_i;
		if (count_i !== last) begin
			age <= 0;
		end else if (age < SETTLE_CYC) begin
			age <= age + 1;
		end
	end

	// noisy while settling, then a clean compare; glitch_i adds a spike
	assign cmp_o = glitch_i | ((age < SETTLE_CYC) ? age[0] : ({1'b0, count_i} >= level_i));
endmodule

// >>> tb/counter_ramp_adc_control_test.sv
// self-checking bench for the converter control and a comparator model
// assumes one 125 MHz clock shared by the control and the model
`timescale 1ns/10ps
module counter_ramp_adc_control_test
	import cadc_pkg::*;
;
	// ------------
	// signals
	// ------------
	logic        clock_i    = 1'b0;
	logic        rst_i      = 1'b1;
	logic        start_i    = 1'b0;
	logic        glitch     = 1'b0;
	logic [8:0]  level      = 9'h000;
	logic        cmp;
	cadc_count_t count_o;
	logic        clear_o;
	logic        busy_o;
	logic        done_o;
	int          num_errors = 0;
	int          checks     = 0;

	cadc_ctrl u_cadc_ctrl (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.start_i (start_i),
		.cmp_i   (cmp),
		.count_o (count_o),
		.clear_o (clear_o),
		.busy_o  (busy_o),
		.done_o  (done_o)
	);

	cadc_cmp_model #(.SETTLE_CYC(20)) u_cadc_cmp_model (
		.clock_i  (clock_i),
		.count_i  (count_o),
		.level_i  (level),
		.glitch_i (glitch),
		.cmp_o    (cmp)
	);

	// 8 ns clock
	initial begin
		forever #4 clock_i = ~clock_i;
	end

	// ------------
	// helpers
	// ------------
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one conversion, watched cycle by cycle; poke adds a spike and a start mid-run
	task automatic run_conv(input logic [8:0] lvl, input logic [7:0] expc, input bit poke);
		int          n;
		int          gap;
		int          clr;
		int          pk;
		cadc_count_t prev;
		level = lvl;
		start_i = 1'b1;
		n = 0;
		while (busy_o !== 1'b1 && n < 10) begin
			tick();
			n++;
		end
		start_i = 1'b0;
		check({clear_o, busy_o, done_o, count_o}, 16'h0600, "start state");
		gap = 0;
		clr = 0;
		pk = 0;
		prev = count_o;
		n = 0;
		while (done_o !== 1'b1 && n < 30000) begin
			if (clear_o === 1'b1) begin
				clr++;
			end
			tick();
			n++;
			gap++;
			if (pk > 0) begin
				pk--;
				if (pk == 0) begin
					glitch = 1'b0;
					start_i = 1'b0;
				end
			end
			if (count_o !== prev) begin
				check(count_o, prev + 8'h01, "count step");
				check(gap >= CADC_STEP_CYC, 1'b1, "step too short");
				gap = 0;
				prev = count_o;
				if (poke && count_o === 8'h02) begin
					glitch = 1'b1;
					start_i = 1'b1;
					pk = 3;
				end
			end
		end
		check(16'(clr), 16'(CADC_CLR_CYC), "clear width");
		check(count_o, expc, "final count");
		check({busy_o, done_o}, 2'h1, "end flags");
	endtask

	// ------------
	// scenarios
	// ------------
	task automatic t_reset();
		check({clear_o, busy_o, done_o, count_o}, 16'h0000, "reset outputs");
		tick();
		rst_i = 1'b0;
		tick();
		check({clear_o, busy_o, done_o, count_o}, 16'h0000, "after release");
		$display("test reset done");
	endtask

	task automatic t_zero();
		run_conv(9'h000, 8'h00, 1'b0);
		$display("test zero done");
	endtask

	task automatic t_mid();
		run_conv(9'h005, 8'h05, 1'b1);
		$display("test mid done");
	endtask

	task automatic t_hold();
		cadc_count_t held;
		int          bad;
		held = count_o;
		bad = 0;
		level = 9'h000;
		repeat (200) begin
			tick();
			if (count_o !== held || done_o !== 1'b1 || busy_o !== 1'b0) begin
				bad++;
			end
		end
		check(16'(bad), 16'h0000, "result moved");
		run_conv(9'h003, 8'h03, 1'b0);
		$display("test hold done");
	endtask

	task automatic t_full();
		run_conv(9'h100, 8'hFF, 1'b0);
		$display("test full done");
	endtask

	// main sequence: reset held 4 cycles
	initial begin
		repeat (3) tick();
		t_reset();
		t_zero();
		t_mid();
		t_hold();
		t_full();
		stop_test();
	end

	// watchdog sized well past the full-scale run
	initial begin
		repeat (60000) @(posedge clock_i);
		num_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		stop_test();
	end
endmodule
